// ---- inc/etc_pkg.sv ----
// constants and types shared by the elapsed-time counter
`default_nettype none
package etc_pkg;
    localparam logic [7:0]  ETC_OFS_MODE        = 8'h00;
    localparam logic [7:0]  ETC_OFS_ALARM       = 8'h04;
    localparam logic [7:0]  ETC_OFS_COUNT       = 8'h08;
    localparam logic [7:0]  ETC_OFS_FLAGS       = 8'h0c;
    localparam logic [15:0] ETC_PRESCALE_RST    = 16'h8000;
    localparam logic [31:0] ETC_ALARM_RST       = 32'hffffffff;
    localparam logic [31:0] ETC_COUNT_RST       = 32'h00000000;
    localparam int          ETC_POS_ALARM_IEN   = 16;
    localparam int          ETC_POS_INC_IEN     = 17;
    localparam int          ETC_POS_RESTART     = 18;
    localparam int          ETC_POS_ALARM_FLAG  = 0;
    localparam int          ETC_POS_INC_FLAG    = 1;
    // slow-clock edges between a request and its effect
    localparam logic [1:0]  ETC_SLOW_DELAY      = 2'h2;

    typedef struct packed {
        logic increment_flag;
        logic alarm_flag;
    } etc_flags_t;

    typedef struct packed {
        logic        increment_irq_enable;
        logic        alarm_irq_enable;
        logic [15:0] prescale_value;
    } etc_mode_t;
endpackage
`default_nettype wire

// ---- rtl/etc_counter.sv ----
// elapsed-time counter: slow-clock prescaler, 32-bit count, alarm, flags, register port
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module etc_counter
    import etc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        slow_clk_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic      [31:0] rd_data_out,
    output logic             irq_out
);

    etc_mode_t   mode_ff;
    logic [31:0] alarm_value_ff;
    logic [31:0] current_count_ff;
    logic [15:0] presc_ff;
    etc_flags_t  flags_ff;
    logic [1:0]  restart_pend_ff;
    logic [1:0]  clear_pend_ff;
    logic        slow_s1_ff;
    logic        slow_s2_ff;
    logic        slow_s3_ff;
    logic [31:0] rd_data_ff;
    logic        irq_ff;
    logic [1:0]  chk_restart_ticks_ff;
    logic [1:0]  chk_clear_ticks_ff;

    logic        slow_tick;
    logic        restart_act;
    logic        clear_act;
    logic        period_end;
    logic        advance;
    logic        alarm_hit;
    logic        wr_mode;
    logic        wr_alarm;
    logic        wr_flags;
    logic        rd_flags;
    etc_flags_t  nxt_flags;
    logic [31:0] nxt_rd_data;
    logic        restart_req;
    logic        clear_req;

    // last prescaler state of a period; zero programs the full 16-bit span
    function automatic logic [15:0] last_step(input logic [15:0] pres);
        last_step = (pres == 16'h0000) ? 16'hffff : pres - 16'h0001;
    endfunction

    // delayed-action counter: armed by a request, fires on the second slow edge
    function automatic logic [1:0] pend_next(input logic [1:0] cur, input logic req,
                                             input logic tick);
        if (req) begin
            pend_next = ETC_SLOW_DELAY;
        end else if (tick && cur != 2'h0) begin
            pend_next = cur - 2'h1;
        end else begin
            pend_next = cur;
        end
    endfunction

    // slow clock arrives unrelated to clk_in; s1 only feeds s2
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slow_s1_ff <= 1'b0;
            slow_s2_ff <= 1'b0;
            slow_s3_ff <= 1'b0;
        end else begin
            slow_s1_ff <= slow_clk_in;
            slow_s2_ff <= slow_s1_ff;
            slow_s3_ff <= slow_s2_ff;
        end
    end

    assign slow_tick = slow_s2_ff & ~slow_s3_ff;

    always_comb begin
        wr_mode  = 1'b0;
        wr_alarm = 1'b0;
        wr_flags = 1'b0;
        rd_flags = 1'b0;
        if (addr_in == ETC_OFS_MODE) begin
            wr_mode = wr_en_in;
        end else if (addr_in == ETC_OFS_ALARM) begin
            wr_alarm = wr_en_in;
        end else if (addr_in == ETC_OFS_FLAGS) begin
            wr_flags = wr_en_in;
            rd_flags = rd_en_in;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_ff <= '{increment_irq_enable: 1'b0, alarm_irq_enable: 1'b0,
                         prescale_value: ETC_PRESCALE_RST};
        end else if (wr_mode) begin
            mode_ff.prescale_value       <= wr_data_in[15:0];
            mode_ff.alarm_irq_enable     <= wr_data_in[ETC_POS_ALARM_IEN];
            mode_ff.increment_irq_enable <= wr_data_in[ETC_POS_INC_IEN];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            alarm_value_ff <= ETC_ALARM_RST;
        end else if (wr_alarm) begin
            alarm_value_ff <= wr_data_in;
        end
    end

    // the other mode bits of a restart write take effect at once
    assign restart_req = wr_mode & wr_data_in[ETC_POS_RESTART];
    assign clear_req   = rd_flags | (wr_flags & |wr_data_in[1:0]);

    // restart counts slow edges so it lands on the second one after the write
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            restart_pend_ff <= 2'h0;
            clear_pend_ff   <= 2'h0;
        end else begin
            restart_pend_ff <= pend_next(restart_pend_ff,
                                         restart_req,
                                         slow_tick);
            // a write of ones to the flags word clears through the same delayed path
            clear_pend_ff   <= pend_next(clear_pend_ff,
                                         clear_req,
                                         slow_tick);
        end
    end

    assign restart_act = slow_tick && (restart_pend_ff == 2'h1);
    assign clear_act   = slow_tick && (clear_pend_ff == 2'h1);
    // lowering the prescale below the prescaler state mid-period without a restart waits for the 16-bit wrap
    assign period_end  = presc_ff == last_step(mode_ff.prescale_value);
    assign advance     = slow_tick && !restart_act && period_end;
    // the hit is the step from alarm value to alarm value plus one
    assign alarm_hit   = advance && (current_count_ff == alarm_value_ff);

    // checker-only tick counts since the last request, parked at three when idle;
    // they let the delay be checked without reading the pending counters
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chk_restart_ticks_ff <= 2'h3;
        end else if (restart_req) begin
            chk_restart_ticks_ff <= 2'h0;
        end else if (slow_tick && chk_restart_ticks_ff != 2'h3) begin
            chk_restart_ticks_ff <= chk_restart_ticks_ff + 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chk_clear_ticks_ff <= 2'h3;
        end else if (clear_req) begin
            chk_clear_ticks_ff <= 2'h0;
        end else if (slow_tick && chk_clear_ticks_ff != 2'h3) begin
            chk_clear_ticks_ff <= chk_clear_ticks_ff + 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            presc_ff         <= 16'h0000;
            current_count_ff <= ETC_COUNT_RST;
        end else if (restart_act) begin
            presc_ff         <= 16'h0000;
            current_count_ff <= ETC_COUNT_RST;
        end else if (advance) begin
            presc_ff         <= 16'h0000;
            current_count_ff <= current_count_ff + 32'h00000001;
        end else if (slow_tick) begin
            presc_ff         <= presc_ff + 16'h0001;
        end
    end

    // a new event in the clearing cycle survives the clear
    always_comb begin
        nxt_flags = flags_ff;
        if (clear_act) begin
            nxt_flags = '0;
        end
        if (advance) begin
            nxt_flags.increment_flag = 1'b1;
        end
        if (alarm_hit) begin
            nxt_flags.alarm_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (flags_ff.alarm_flag && mode_ff.alarm_irq_enable) ||
                      (flags_ff.increment_flag && mode_ff.increment_irq_enable);
        end
    end

    always_comb begin
        nxt_rd_data = 32'h00000000;
        if (addr_in == ETC_OFS_MODE) begin
            nxt_rd_data[15:0]              = mode_ff.prescale_value;
            nxt_rd_data[ETC_POS_ALARM_IEN] = mode_ff.alarm_irq_enable;
            nxt_rd_data[ETC_POS_INC_IEN]   = mode_ff.increment_irq_enable;
        end else if (addr_in == ETC_OFS_ALARM) begin
            nxt_rd_data = alarm_value_ff;
        end else if (addr_in == ETC_OFS_COUNT) begin
            // count lives in this domain, so no torn value reaches the bus
            nxt_rd_data = current_count_ff;
        end else if (addr_in == ETC_OFS_FLAGS) begin
            nxt_rd_data[ETC_POS_ALARM_FLAG] = flags_ff.alarm_flag;
            nxt_rd_data[ETC_POS_INC_FLAG]   = flags_ff.increment_flag;
        end
    end

    // data only in the cycle after the read strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_ff <= 32'h00000000;
        end else if (rd_en_in) begin
            rd_data_ff <= nxt_rd_data;
        end else begin
            rd_data_ff <= 32'h00000000;
        end
    end

    assign rd_data_out = rd_data_ff;
    assign irq_out     = irq_ff;

    AST_PERIOD_ADVANCE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (slow_tick && !restart_act && period_end && current_count_ff != 32'hffffffff)
        |=> current_count_ff == $past(current_count_ff) + 32'h00000001)
        else $error("count did not advance at prescaler period end");

    AST_ZERO_PRESCALE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (advance && mode_ff.prescale_value == 16'h0000) |-> presc_ff == 16'hffff)
        else $error("zero prescale did not span the full 16-bit period");

    AST_WRAP: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (advance && current_count_ff == 32'hffffffff) |=> current_count_ff == 32'h00000000)
        else $error("count did not wrap to zero");

    AST_ALARM_SET: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (advance && current_count_ff == alarm_value_ff) |=> flags_ff.alarm_flag)
        else $error("alarm flag not set at alarm plus one");

    AST_ALARM_RESET: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(resetn_in) |-> alarm_value_ff == 32'hffffffff)
        else $error("alarm value not all ones after reset");

    AST_INC_SET: assert property (@(posedge clk_in) disable iff (!resetn_in)
        advance |=> flags_ff.increment_flag)
        else $error("increment flag not set on advance");

    AST_CLEAR_HOLD: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rd_flags && flags_ff.alarm_flag && !clear_act) |=> flags_ff.alarm_flag)
        else $error("flag cleared before two slow cycles");

    AST_CLEAR_DONE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (clear_act && !advance) |=> flags_ff == '0)
        else $error("flags not cleared at delayed clear");

    AST_IRQ_ALARM: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (flags_ff.alarm_flag && mode_ff.alarm_irq_enable) |=> irq_out)
        else $error("enabled alarm flag did not raise interrupt");

    AST_IRQ_QUIET: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!mode_ff.increment_irq_enable && !mode_ff.alarm_irq_enable) |=> !irq_out)
        else $error("interrupt with both enables clear");

    AST_RESTART: assert property (@(posedge clk_in) disable iff (!resetn_in)
        restart_act |=> (current_count_ff == 32'h00000000 && presc_ff == 16'h0000))
        else $error("restart did not zero counter and prescaler");

    AST_COUNT_READ: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rd_en_in && addr_in == ETC_OFS_COUNT) |=> rd_data_out == $past(current_count_ff))
        else $error("count read returned wrong value");

    // register port checks
    AST_ALARM_WRITE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_alarm |=> alarm_value_ff == $past(wr_data_in))
        else $error("alarm value write not taken");

    AST_ALARM_READ: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rd_en_in && addr_in == ETC_OFS_ALARM) |=> rd_data_out == $past(alarm_value_ff))
        else $error("alarm read returned wrong value");

    AST_MODE_WRITE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_mode |=> mode_ff.prescale_value == $past(wr_data_in[15:0]))
        else $error("new prescale value not taken at once");

    AST_MODE_READ: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rd_en_in && addr_in == ETC_OFS_MODE) |=> rd_data_out == {14'h0000, $past(mode_ff)})
        else $error("mode read returned wrong value");

    AST_FLAGS_READ: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rd_en_in && addr_in == ETC_OFS_FLAGS) |=> rd_data_out == {30'h0, $past(flags_ff)})
        else $error("flags read returned wrong value");

    AST_RD_IDLE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !rd_en_in |=> rd_data_out == 32'h00000000)
        else $error("read data outside the cycle after a read");

    AST_RESET_OUT: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(resetn_in) |-> (rd_data_out == 32'h00000000 && !irq_out))
        else $error("outputs not quiet after reset");

    // counting and flag checks
    AST_COUNT_STILL: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!advance && !restart_act) |=> $stable(current_count_ff))
        else $error("count moved without a period end");

    AST_PRESC_STILL: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !slow_tick |=> $stable(presc_ff))
        else $error("prescaler moved without a slow edge");

    AST_INC_ONLY: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!flags_ff.increment_flag && !advance) |=> !flags_ff.increment_flag)
        else $error("increment flag set without an advance");

    AST_ALARM_ONLY: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!flags_ff.alarm_flag && !alarm_hit) |=> !flags_ff.alarm_flag)
        else $error("alarm flag set without a match");

    AST_SET_WINS: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (clear_act && advance) |=> flags_ff.increment_flag)
        else $error("increment lost to a clear in the same cycle");

    AST_IRQ_INC: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (flags_ff.increment_flag && mode_ff.increment_irq_enable) |=> irq_out)
        else $error("enabled increment flag did not raise interrupt");

    AST_RESTART_LATE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        restart_act |-> chk_restart_ticks_ff == 2'h1)
        else $error("restart not on the second slow edge");

    AST_RESTART_DUE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (slow_tick && chk_restart_ticks_ff == 2'h1 && !restart_req) |-> restart_act)
        else $error("restart missed its second slow edge");

    AST_CLEAR_LATE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        clear_act |-> chk_clear_ticks_ff == 2'h1)
        else $error("flag clear not on the second slow edge");

    AST_CLEAR_DUE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (slow_tick && chk_clear_ticks_ff == 2'h1 && !clear_req) |-> clear_act)
        else $error("flag clear missed its second slow edge");

endmodule
`default_nettype wire

// ---- tb/test_slow_clock_elapsed_time_counter.sv ----
// self-checking bench for the elapsed-time counter with a bench-paced slow clock
`timescale 1ns/100ps
`default_nettype none
module test_slow_clock_elapsed_time_counter;
    import etc_pkg::*;
    localparam int LIMIT = 20000;
    logic        clk_in;
    logic        resetn;
    logic        slow_clk;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        irq;
    logic        rd_seen;
    logic [31:0] exp_v;
    logic [31:0] rnd;
    logic [31:0] exp_q[$];
    int          fails;
    int          n_checks;
    int          cycles;
    int          seed;

    etc_counter etc_counter_i (
        .clk_in      (clk_in),
        .resetn_in   (resetn),
        .slow_clk_in (slow_clk),
        .addr_in     (addr),
        .wr_data_in  (wr_data),
        .wr_en_in    (wr_en),
        .rd_en_in    (rd_en),
        .rd_data_out (rd_data),
        .irq_out     (irq)
    );

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk_in);
        wr_en   <= 1'b0;
    endtask

    // the note is queued when the read is issued; the monitor pops it when data stand
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        rd_en <= 1'b1;
        addr  <= a;
        exp_q.push_back(exp);
        @(posedge clk_in);
        rd_en <= 1'b0;
    endtask

    // whole slow periods, 4 clocks high and 4 low, then idle so the count is still when read
    task automatic slow(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge clk_in);
            slow_clk <= ~slow_clk;
        end
        repeat (8) @(posedge clk_in);
    endtask

    task automatic chk_irq(input logic e);
        repeat (3) @(posedge clk_in);
        cmp({31'h0, irq}, {31'h0, e});
    endtask

    always @(posedge clk_in) begin
        rd_seen <= rd_en;
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("Error at %0t: read data with no note queued", $time);
            end else begin
                exp_v = exp_q.pop_front();
                cmp(rd_data, exp_v);
            end
        end
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            $display("Error at %0t: run did not finish in time", $time);
            print_verdict();
        end
    end

    initial begin
        resetn   = 1'b0;
        slow_clk = 1'b0;
        addr     = 8'h00;
        wr_data  = 32'h0;
        wr_en    = 1'b0;
        rd_en    = 1'b0;
        fails    = 0;
        n_checks = 0;
        seed     = 80762;
        repeat (2) @(posedge clk_in);
        resetn <= 1'b1;
        rd(ETC_OFS_MODE, 32'h00008000);
        rd(ETC_OFS_ALARM, ETC_ALARM_RST);
        rd(ETC_OFS_COUNT, 32'h0);
        rd(ETC_OFS_FLAGS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            wr(ETC_OFS_ALARM, rnd);
            rd(ETC_OFS_ALARM, rnd);
            rnd = $random(seed) & 32'h0003ffff;
            wr(ETC_OFS_MODE, rnd);
            rd(ETC_OFS_MODE, rnd);
            wr(8'h10, rnd);
            rd(8'h10, 32'h0);
            wr(ETC_OFS_COUNT, rnd);
            rd(ETC_OFS_COUNT, 32'h0);
        end
        // alarm value 1 means the flag rises on the step from 1 to 2
        wr(ETC_OFS_ALARM, 32'h1);
        wr(ETC_OFS_MODE, 32'h00040003);
        slow(2);
        rd(ETC_OFS_COUNT, 32'h0);
        slow(3);
        rd(ETC_OFS_COUNT, 32'h1);
        rd(ETC_OFS_FLAGS, 32'h2);
        slow(2);
        rd(ETC_OFS_FLAGS, 32'h0);
        slow(1);
        rd(ETC_OFS_COUNT, 32'h2);
        chk_irq(1'b0);
        wr(ETC_OFS_MODE, 32'h00010003);
        chk_irq(1'b1);
        wr(ETC_OFS_MODE, 32'h00020003);
        chk_irq(1'b1);
        rd(ETC_OFS_FLAGS, 32'h3);
        slow(1);
        chk_irq(1'b1);
        slow(1);
        chk_irq(1'b0);
        rd(ETC_OFS_FLAGS, 32'h0);
        slow(1);
        chk_irq(1'b1);
        // restart lands on the second slow edge; the new prescale of one counts meanwhile
        wr(ETC_OFS_MODE, 32'h00040001);
        slow(1);
        rd(ETC_OFS_COUNT, 32'h4);
        slow(1);
        rd(ETC_OFS_COUNT, 32'h0);
        slow(5);
        rd(ETC_OFS_COUNT, 32'h5);
        // handler style: mask on entry, read flags, unmask once the clear has landed
        wr(ETC_OFS_MODE, 32'h00000003);
        rd(ETC_OFS_FLAGS, 32'h3);
        chk_irq(1'b0);
        slow(2);
        wr(ETC_OFS_MODE, 32'h00030003);
        chk_irq(1'b0);
        rd(ETC_OFS_COUNT, 32'h5);
        rd(ETC_OFS_COUNT, 32'h5);
        slow(1);
        chk_irq(1'b1);
        // a one written to the flags word takes the same delayed clear
        wr(ETC_OFS_FLAGS, 32'h2);
        slow(1);
        chk_irq(1'b1);
        slow(1);
        chk_irq(1'b0);
        rd(ETC_OFS_FLAGS, 32'h0);
        rd(ETC_OFS_COUNT, 32'h6);
        repeat (4) @(posedge clk_in);
        print_verdict();
    end
endmodule
`default_nettype wire
